// ---- sideband_pkg.sv ----
// Functional notes
// RL1 - Machine check: fatal output low 16 clocks.
// RL2 - Internal fault: fatal output held until reset.
// RL3 - Unrecoverable faults drive the fatal error output.
// RL4 - Temperature limit drives thermal hot pin low.
// RL5 - Thermal hot driven externally engages throttling.
// RL6 - Trip sensor halts execution, asserts trip output.
// RL7 - Test reset low resets test port logic.
// RL8 - Host holds test reset low during reset.
// RL9 - Host keeps test clock low during reset.
// RL10 - Debug tool pulls debug request low.
// RL11 - Device drives active-low debug ready output.
// RL12 - Power ok stays low, then rises cleanly.
// RL13 - Breakpoint lines show breakpoint and counter status.
// RL14 - Debug reset output forces platform reset.
// RL15 - Test port shifts data; open-drain data out.
// RL16 - Asynchronous inputs pass two-stage synchronisers first; the code leaves tck, tms, tdi and trst_n unsynchronised.
package sideband_pkg;
   localparam int FATAL_PULSE_CYCLES = 16;
   localparam int BPM_WIDTH = 8;
   localparam int TAP_WIDTH = 16;
   localparam int SYNC_STAGES = 2;
   localparam int TCK_HALF_CYCLES = 4;
   localparam int TCK_HALF_MIN = 4;
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 32;
   localparam int EVENT_COUNT = 5;

   localparam logic [7:0] STATUS_OFFSET = 8'h00;
   localparam logic [7:0] CLEAR_OFFSET = 8'h04;
   localparam logic [7:0] ENABLE_OFFSET = 8'h08;
   localparam logic [7:0] CONTROL_OFFSET = 8'h0c;
   localparam logic [7:0] TAP_OFFSET = 8'h10;
   localparam logic [7:0] PINS_OFFSET = 8'h14;

   localparam int EV_FATAL = 0;
   localparam int EV_TRIP = 1;
   localparam int EV_HOT = 2;
   localparam int EV_DEBUG_READY = 3;
   localparam int EV_TAP_DONE = 4;

   localparam int CTL_POWER_OK = 0;
   localparam int CTL_DEBUG_REQ = 1;
   localparam int CTL_HOT_FORCE = 2;
   localparam int CTL_TAP_RELEASE = 3;
   localparam int CONTROL_WIDTH = 4;
   localparam logic [3:0] CONTROL_RESET = 4'h0;

   localparam int SYNC_DEBUG_REQ = 0;
   localparam int SYNC_POWER_OK = 1;
   localparam int SYNC_HOT = 2;
   localparam int SYNC_COUNT = 3;
   localparam logic [2:0] SYNC_RESET = 3'h5;

   typedef enum logic [1:0] {
      DBG_RUN = 2'h0,
      DBG_ENTER = 2'h1,
      DBG_READY = 2'h3,
      DBG_EXIT = 2'h2
   } debug_state_t;
endpackage

// ---- sideband_if.sv ----
interface sideband_if;
   import sideband_pkg::*;
   logic fatal_error_n;
   logic thermal_trip_n;
   logic debug_ready_n;
   logic debug_request_n;
   logic [BPM_WIDTH-1:0] breakpoint_monitor_n;
   logic debug_reset_out_n;
   logic uncore_power_ok;
   logic dev_hot_oe_n;
   logic host_hot_oe_n;
   logic thermal_hot_n;
   logic tck;
   logic tms;
   logic tdi;
   logic trst_n;
   logic tdo_oe_n;
   logic tdo;

   // Open-drain lines with pull-up: low while any end enables its driver.
   assign thermal_hot_n = dev_hot_oe_n & host_hot_oe_n;
   assign tdo = tdo_oe_n;

   modport device_end (
      output fatal_error_n, thermal_trip_n, debug_ready_n, breakpoint_monitor_n,
      output debug_reset_out_n, dev_hot_oe_n, tdo_oe_n,
      input debug_request_n, uncore_power_ok, thermal_hot_n, tck, tms, tdi, trst_n
   );
   modport host_end (
      input fatal_error_n, thermal_trip_n, debug_ready_n, breakpoint_monitor_n,
      input debug_reset_out_n, thermal_hot_n, tdo,
      output debug_request_n, uncore_power_ok, host_hot_oe_n, tck, tms, tdi, trst_n
   );
endinterface

// ---- sideband_device.sv ----
module sideband_device
   import sideband_pkg::*;
#(
   parameter int PULSE_CYCLES = FATAL_PULSE_CYCLES,
   parameter int SCAN_WIDTH = TAP_WIDTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   sideband_if.device_end pins,
   input wire logic machine_check_fault,
   input wire logic internal_fault,
   input wire logic temp_at_limit,
   input wire logic throttle_enable,
   input wire logic trip_sensor,
   input wire logic [BPM_WIDTH-1:0] breakpoint_hit,
   input wire logic [BPM_WIDTH-1:0] counter_overflow,
   input wire logic debug_halted,
   input wire logic debug_reset_req,
   output logic throttle_active,
   output logic exec_halt,
   output logic debug_mode,
   output logic power_ok
);
   // The shift chain below needs at least two stages to have a first flop to hide.
   if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255 || SYNC_STAGES < 2) begin : g_bad_pulse
      $error("PULSE_CYCLES or SYNC_STAGES out of range");
   end
   if (SCAN_WIDTH < 8) begin : g_bad_scan
      $error("SCAN_WIDTH must be at least 8");
   end

   localparam logic [7:0] PULSE_LOAD = 8'(PULSE_CYCLES);

   logic [SYNC_COUNT-1:0] async_in;
   logic [SYNC_COUNT-1:0] synced;
   logic [7:0] pulse_cnt_reg;
   logic held_fault_reg;
   logic trip_reg;
   logic hot_drive;
   debug_state_t dbg_reg;
   debug_state_t dbg_next;
   logic tck_prev_reg;
   logic tck_rise;
   logic tck_fall;
   logic [SCAN_WIDTH-1:0] scan_reg;
   logic scan_active_reg;

   assign async_in[SYNC_DEBUG_REQ] = pins.debug_request_n;
   assign async_in[SYNC_POWER_OK] = pins.uncore_power_ok;
   assign async_in[SYNC_HOT] = pins.thermal_hot_n;

   // Only the last stage of each chain is read by the logic below.
   for (genvar i = 0; i < SYNC_COUNT; i++) begin : g_sync
      logic [SYNC_STAGES-1:0] chain_reg;
      always_ff @(posedge ref_clk) begin
         if (rst) begin
            chain_reg <= {SYNC_STAGES{SYNC_RESET[i]}};
         end else begin
            chain_reg <= {chain_reg[SYNC_STAGES-2:0], async_in[i]}; // RL16
         end
      end
      assign synced[i] = chain_reg[SYNC_STAGES-1];
   end

   // A new machine check restarts the full pulse.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pulse_cnt_reg <= 8'h00;
      end else if (machine_check_fault) begin
         pulse_cnt_reg <= PULSE_LOAD; // RL1
      end else if (pulse_cnt_reg != 8'h00) begin
         pulse_cnt_reg <= pulse_cnt_reg - 8'h01; // RL1
      end
   end

   // Only a warm or cold reset, which is rst here, lets go of this.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         held_fault_reg <= 1'b0;
      end else if (internal_fault) begin
         held_fault_reg <= 1'b1; // RL2
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pins.fatal_error_n <= 1'b1;
      end else begin
         pins.fatal_error_n <= !(held_fault_reg || pulse_cnt_reg != 8'h00); // RL3
      end
   end

   // The trip latches so execution stays stopped until reset.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trip_reg <= 1'b0;
      end else if (trip_sensor) begin
         trip_reg <= 1'b1; // RL6
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pins.thermal_trip_n <= 1'b1;
         exec_halt <= 1'b0;
      end else begin
         pins.thermal_trip_n <= !(trip_reg || trip_sensor); // RL6
         exec_halt <= trip_reg || trip_sensor; // RL6
      end
   end

   assign hot_drive = temp_at_limit && throttle_enable;

   // The synced pin also sees our own drive, which only keeps throttling on.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pins.dev_hot_oe_n <= 1'b1;
         throttle_active <= 1'b0;
      end else begin
         pins.dev_hot_oe_n <= !hot_drive; // RL4
         throttle_active <= hot_drive || !synced[SYNC_HOT]; // RL5
      end
   end

   always_comb begin
      dbg_next = dbg_reg;
      case (dbg_reg)
         DBG_RUN: begin
            if (!synced[SYNC_DEBUG_REQ]) begin
               dbg_next = DBG_ENTER; // RL10
            end
         end
         DBG_ENTER: begin
            if (debug_halted) begin
               dbg_next = DBG_READY;
            end
         end
         DBG_READY: begin
            if (synced[SYNC_DEBUG_REQ]) begin
               dbg_next = DBG_EXIT;
            end
         end
         DBG_EXIT: begin
            if (!debug_halted) begin
               dbg_next = DBG_RUN;
            end
         end
         default: dbg_next = DBG_RUN;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dbg_reg <= DBG_RUN;
         pins.debug_ready_n <= 1'b1;
         debug_mode <= 1'b0;
      end else begin
         dbg_reg <= dbg_next;
         pins.debug_ready_n <= dbg_next != DBG_READY; // RL11
         debug_mode <= dbg_next != DBG_RUN;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pins.breakpoint_monitor_n <= '1;
         pins.debug_reset_out_n <= 1'b1;
         power_ok <= 1'b0;
      end else begin
         pins.breakpoint_monitor_n <= ~(breakpoint_hit | counter_overflow); // RL13
         pins.debug_reset_out_n <= !debug_reset_req;
         power_ok <= synced[SYNC_POWER_OK];
      end
   end

   // The test clock is slow against ref_clk, so its edges are found by sampling.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tck_prev_reg <= 1'b0;
      end else begin
         tck_prev_reg <= pins.tck;
      end
   end

   assign tck_rise = pins.tck && !tck_prev_reg;
   assign tck_fall = !pins.tck && tck_prev_reg;

   // TMS high captures a status word, TMS low shifts one bit LSB first.
   always_ff @(posedge ref_clk) begin
      if (rst || !pins.trst_n) begin
         scan_reg <= '0; // RL7
         scan_active_reg <= 1'b0; // RL7
      end else if (tck_rise && pins.tms) begin
         scan_reg <= SCAN_WIDTH'({dbg_reg, trip_reg, held_fault_reg, !synced[SYNC_HOT],
                                  synced[SYNC_POWER_OK]}); // RL15
         scan_active_reg <= 1'b1;
      end else if (tck_rise) begin
         scan_reg <= {pins.tdi, scan_reg[SCAN_WIDTH-1:1]}; // RL15
      end
   end

   // The output bit changes on the falling edge, a half period before it is sampled.
   always_ff @(posedge ref_clk) begin
      if (rst || !pins.trst_n) begin
         pins.tdo_oe_n <= 1'b1; // RL7
      end else if (tck_fall) begin
         pins.tdo_oe_n <= !(scan_active_reg && !scan_reg[0]); // RL15
      end
   end
endmodule

// ---- sideband_host.sv ----
module sideband_host
   import sideband_pkg::*;
#(
   parameter int TCK_HALF = TCK_HALF_CYCLES,
   parameter int SCAN_WIDTH = TAP_WIDTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   sideband_if.host_end pins,
   input wire logic [ADDR_WIDTH-1:0] addr,
   input wire logic [DATA_WIDTH-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_WIDTH-1:0] rdata,
   output logic irq,
   output logic platform_reset
);
   // The busy flag sits above the result word, so the word must leave it a bit.
   if (TCK_HALF < TCK_HALF_MIN || TCK_HALF > 255) begin : g_bad_half
      $error("TCK_HALF out of range");
   end
   if (SCAN_WIDTH < 8 || SCAN_WIDTH > DATA_WIDTH - 1) begin : g_bad_scan
      $error("SCAN_WIDTH out of range");
   end

   localparam logic [7:0] HALF_LOAD = 8'(TCK_HALF - 1);
   localparam logic [5:0] SCAN_LOAD = 6'(SCAN_WIDTH + 1);

   logic [EVENT_COUNT-1:0] status_reg;
   logic [EVENT_COUNT-1:0] enable_reg;
   logic [EVENT_COUNT-1:0] event_set;
   logic [EVENT_COUNT-1:0] clear_bits;
   logic [CONTROL_WIDTH-1:0] control_reg;
   logic [3:0] prev_reg;
   logic [7:0] div_reg;
   logic tick;
   logic busy_reg;
   logic [5:0] bits_reg;
   logic [SCAN_WIDTH-1:0] tx_reg;
   logic [SCAN_WIDTH-1:0] rx_reg;
   logic tap_done;
   logic tap_start;

   assign tap_start = wr && addr == TAP_OFFSET && !busy_reg && pins.trst_n;
   assign clear_bits = (wr && addr == CLEAR_OFFSET) ? wdata[EVENT_COUNT-1:0] : '0;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prev_reg <= 4'hf;
      end else begin
         prev_reg <= {pins.debug_ready_n, pins.thermal_hot_n, pins.thermal_trip_n,
                      pins.fatal_error_n};
      end
   end

   assign event_set[EV_FATAL] = prev_reg[0] && !pins.fatal_error_n;
   assign event_set[EV_TRIP] = prev_reg[1] && !pins.thermal_trip_n;
   assign event_set[EV_HOT] = prev_reg[2] && !pins.thermal_hot_n;
   assign event_set[EV_DEBUG_READY] = prev_reg[3] && !pins.debug_ready_n;
   assign event_set[EV_TAP_DONE] = tap_done;

   // A set in the same cycle as its clear survives.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_reg <= '0;
      end else begin
         status_reg <= (status_reg & ~clear_bits) | event_set;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         enable_reg <= '0;
         control_reg <= CONTROL_RESET;
      end else if (wr && addr == ENABLE_OFFSET) begin
         enable_reg <= wdata[EVENT_COUNT-1:0];
      end else if (wr && addr == CONTROL_OFFSET) begin
         control_reg <= wdata[CONTROL_WIDTH-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((status_reg & ~clear_bits) | event_set) & enable_reg);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            STATUS_OFFSET: rdata <= DATA_WIDTH'(status_reg);
            ENABLE_OFFSET: rdata <= DATA_WIDTH'(enable_reg);
            CONTROL_OFFSET: rdata <= DATA_WIDTH'(control_reg);
            TAP_OFFSET: rdata <= DATA_WIDTH'({busy_reg, rx_reg});
            PINS_OFFSET: rdata <= DATA_WIDTH'({pins.breakpoint_monitor_n, prev_reg});
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // Pins leave reset in their safe levels and change only from flops.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pins.uncore_power_ok <= 1'b0; // RL12
         pins.debug_request_n <= 1'b1;
         pins.host_hot_oe_n <= 1'b1;
         pins.trst_n <= 1'b0; // RL8
         platform_reset <= 1'b0;
      end else begin
         pins.uncore_power_ok <= control_reg[CTL_POWER_OK]; // RL12
         pins.debug_request_n <= !control_reg[CTL_DEBUG_REQ]; // RL10
         pins.host_hot_oe_n <= !control_reg[CTL_HOT_FORCE]; // RL5
         pins.trst_n <= control_reg[CTL_TAP_RELEASE]; // RL8
         platform_reset <= !pins.debug_reset_out_n; // RL14
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !busy_reg) begin
         div_reg <= HALF_LOAD;
      end else if (div_reg == 8'h00) begin
         div_reg <= HALF_LOAD;
      end else begin
         div_reg <= div_reg - 8'h01;
      end
   end

   assign tick = busy_reg && div_reg == 8'h00;
   assign tap_done = tick && pins.tck && bits_reg == 6'h01;

   // One capture clock with TMS high, then SCAN_WIDTH shift clocks with TMS low.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pins.tck <= 1'b0; // RL9
         pins.tms <= 1'b1;
         pins.tdi <= 1'b1;
         busy_reg <= 1'b0;
         bits_reg <= 6'h00;
         tx_reg <= '0;
         rx_reg <= '0;
      end else if (tap_start) begin
         busy_reg <= 1'b1;
         bits_reg <= SCAN_LOAD;
         pins.tms <= 1'b1;
         tx_reg <= wdata[SCAN_WIDTH-1:0];
      end else if (tick && !pins.tck) begin
         pins.tck <= 1'b1; // RL15
         if (!pins.tms) begin
            rx_reg <= {pins.tdo, rx_reg[SCAN_WIDTH-1:1]}; // RL15
         end
      end else if (tick) begin
         pins.tck <= 1'b0;
         bits_reg <= bits_reg - 6'h01;
         pins.tms <= 1'b0;
         pins.tdi <= tx_reg[0];
         tx_reg <= {1'b0, tx_reg[SCAN_WIDTH-1:1]};
         if (bits_reg == 6'h01) begin
            busy_reg <= 1'b0;
            pins.tms <= 1'b1;
         end
      end
   end
endmodule

// ---- sideband_props.sv ----
module sideband_props (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic fatal_error_n,
   input wire logic thermal_trip_n,
   input wire logic debug_ready_n,
   input wire logic debug_request_n,
   input wire logic dev_hot_oe_n,
   input wire logic tdo_oe_n,
   input wire logic trst_n,
   input wire logic tck
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // An internal fault holds the line longer, so only the lower bound is checked here.
   sequence fatal_held_s;
      !fatal_error_n [*8] ##1 !fatal_error_n [*8];
   endsequence

   sequence request_seen_s;
      $past(debug_request_n, 3) == 1'b0;
   endsequence

   fatal_pulse_a: assert property ($fell(fatal_error_n) |-> fatal_held_s)
      else $error("fatal output released before sixteen cycles");
   trip_hold_a: assert property (!thermal_trip_n |=> !thermal_trip_n)
      else $error("trip output released without reset");
   ready_needs_request_a: assert property ($fell(debug_ready_n) |-> request_seen_s)
      else $error("debug ready without a synchronised request");
   ready_release_a: assert property ($rose(debug_ready_n) |-> $past(debug_request_n, 2))
      else $error("debug ready dropped while request still low");
   tap_reset_a: assert property (!trst_n [*3] |-> tdo_oe_n)
      else $error("test data out driven while test reset low");
   tdo_drive_a: assert property ($fell(tdo_oe_n) |-> trst_n && !tck)
      else $error("test data out changed outside a low test clock");
   reset_idle_a: assert property ($fell(rst) |->
         fatal_error_n && thermal_trip_n && debug_ready_n && dev_hot_oe_n)
      else $error("device pins not idle after reset");
   host_reset_a: assert property ($fell(rst) |-> !trst_n && !tck)
      else $error("test reset or test clock wrong after reset");
endmodule

// ---- processor_sideband_signals_bench.sv ----
module processor_sideband_signals_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import sideband_pkg::*;

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic mcf = 1'b0, ifault = 1'b0, temp = 1'b0, thr_en = 1'b0, trip = 1'b0;
   logic halted = 1'b0, dbg_rst = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] hit = 8'h00, ovf = 8'h00, addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic irq, plat_rst, throttle, halt, dmode, pok;
   int failures = 0, n_checks = 0, cnt;

   sideband_if sb();
   sideband_device u_sideband_device (.ref_clk(ref_clk), .rst(rst), .pins(sb),
      .machine_check_fault(mcf), .internal_fault(ifault), .temp_at_limit(temp),
      .throttle_enable(thr_en), .trip_sensor(trip), .breakpoint_hit(hit),
      .counter_overflow(ovf), .debug_halted(halted), .debug_reset_req(dbg_rst),
      .throttle_active(throttle), .exec_halt(halt), .debug_mode(dmode), .power_ok(pok));
   sideband_host u_sideband_host (.ref_clk(ref_clk), .rst(rst), .pins(sb), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .platform_reset(plat_rst));
   sideband_props u_sideband_props (.ref_clk(ref_clk), .rst(rst),
      .fatal_error_n(sb.fatal_error_n), .thermal_trip_n(sb.thermal_trip_n),
      .debug_ready_n(sb.debug_ready_n), .debug_request_n(sb.debug_request_n),
      .dev_hot_oe_n(sb.dev_hot_oe_n), .tdo_oe_n(sb.tdo_oe_n), .trst_n(sb.trst_n),
      .tck(sb.tck));

   always #2.5 ref_clk = ~ref_clk;

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic put_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   task automatic get_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // The tests need under four hundred cycles; fifty times that means a hang.
   initial begin
      #100000;
      failures++;
      final_report;
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      get_reg(STATUS_OFFSET, v);
      chk(v, 32'h0);
      get_reg(PINS_OFFSET, v);
      chk(v, 32'h0000_0fff);
      get_reg(8'h20, v);
      chk(v, 32'h0);
      put_reg(ENABLE_OFFSET, 32'h1f);
      get_reg(ENABLE_OFFSET, v);
      chk(v, 32'h1f);
      // A scan started while test reset is still low must be ignored.
      put_reg(TAP_OFFSET, 32'ha5a5);
      get_reg(TAP_OFFSET, v);
      chk(v, 32'h0);
      put_reg(CONTROL_OFFSET, 32'h9);
      tick(5);
      chk(pok, 1'b1);
      put_reg(TAP_OFFSET, 32'ha5a5);
      for (int i = 0; i < 400 && irq !== 1'b1; i++) tick(1);
      chk(irq, 1'b1);
      get_reg(TAP_OFFSET, v);
      chk(v & 32'h0001_003f, 32'h1);
      get_reg(STATUS_OFFSET, v);
      chk(v, 32'h10);
      put_reg(CLEAR_OFFSET, 32'h1f);
      tick(3);
      chk(irq, 1'b0);
      @(posedge ref_clk) mcf <= 1'b1;
      @(posedge ref_clk) mcf <= 1'b0;
      cnt = 0;
      repeat (40) begin
         tick(1);
         if (sb.fatal_error_n === 1'b0) cnt++;
      end
      chk(cnt, FATAL_PULSE_CYCLES);
      chk(irq, 1'b1);
      put_reg(ENABLE_OFFSET, 32'h0);
      tick(3);
      chk(irq, 1'b0);
      get_reg(STATUS_OFFSET, v);
      chk(v, 32'h1);
      put_reg(CLEAR_OFFSET, 32'h1);
      get_reg(STATUS_OFFSET, v);
      chk(v, 32'h0);
      put_reg(ENABLE_OFFSET, 32'h1f);
      @(posedge ref_clk) begin
         hit <= 8'h05;
         ovf <= 8'h30;
      end
      tick(3);
      get_reg(PINS_OFFSET, v);
      chk(v[11:4], 8'hca);
      @(posedge ref_clk) begin
         temp <= 1'b1;
         thr_en <= 1'b1;
      end
      tick(3);
      chk(sb.thermal_hot_n, 1'b0);
      @(posedge ref_clk) temp <= 1'b0;
      put_reg(CONTROL_OFFSET, 32'hd);
      tick(5);
      chk(throttle, 1'b1);
      put_reg(CONTROL_OFFSET, 32'hb);
      tick(8);
      chk({dmode, sb.debug_ready_n}, 2'b11);
      @(posedge ref_clk) halted <= 1'b1;
      tick(3);
      chk(sb.debug_ready_n, 1'b0);
      put_reg(CONTROL_OFFSET, 32'h9);
      @(posedge ref_clk) halted <= 1'b0;
      tick(10);
      chk({dmode, sb.debug_ready_n}, 2'b01);
      @(posedge ref_clk) dbg_rst <= 1'b1;
      tick(4);
      chk({sb.debug_reset_out_n, plat_rst}, 2'b01);
      @(posedge ref_clk) dbg_rst <= 1'b0;
      @(posedge ref_clk) ifault <= 1'b1;
      @(posedge ref_clk) ifault <= 1'b0;
      tick(40);
      chk(sb.fatal_error_n, 1'b0);
      @(posedge ref_clk) trip <= 1'b1;
      @(posedge ref_clk) trip <= 1'b0;
      tick(3);
      chk({sb.thermal_trip_n, halt}, 2'b01);
      get_reg(STATUS_OFFSET, v);
      chk(v, 32'hf);
      @(posedge ref_clk) rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      tick(2);
      chk({sb.fatal_error_n, sb.thermal_trip_n}, 2'b11);
      get_reg(STATUS_OFFSET, v);
      chk(v, 32'h0);
      final_report;
   end
endmodule
